// File: rotate_subtract_swap_alu.sv
// APB-reached execution block: rotates, subtracts, swap, sleep effects
// Notes on behaviour
// - Rotate right through carry, only carry changes
// - Destination bit 0 to accumulator, 1 to file
// - Sleep zeroes watchdog counter and its prescaler
// - Sleep sets timeout flag, clears power-down flag
// - Literal minus accumulator, result into accumulator
// - Literal subtract carry and digit carry meaning
// - File minus accumulator, routed by destination
// - File subtract carry and digit carry meaning
// - Accumulator minus file minus borrow, flags updated
// - Nibble exchange, routed, flags untouched
// - Rotate left through carry, only carry changes
//
// The APB register port and the placing of the registers were decided locally.

// Register map, one aligned 32-bit word each:
// control at 0x00: operation, destination, start bit
// operand at 0x04: literal and 7-bit file address
// accumulator at 0x08, file operand mirror at 0x0C
// status at 0x10: arithmetic and power flags
// watchdog counter at 0x14, read only
// Timing: zero wait states on the bus; a start
// write runs the operation in the next cycle and
// the block is busy for two cycles after it.
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_swap_alu
    import alu_ops_pkg::*;
#(
    parameter int PRESCALE = WDOG_PRESCALE
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [6:0] fileAddr,
    output logic [7:0] fileWrData,
    output logic fileWrEn,
    output logic sleeping
);

    // Elaboration check on the prescaler ratio
    if (PRESCALE < 2 || PRESCALE > 65536) begin : g_bad_prescale
        $error("PRESCALE must lie between 2 and 65536");
    end

    // Prescaler width; a ratio of two needs a single bit
    localparam int PW = $clog2(PRESCALE);

    // Gray order along idle, execute, done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b11
    } exec_state_t;

    exec_state_t state_ff;
    logic [3:0] opSel_ff;
    logic destFile_ff;
    logic [7:0] literal_ff;
    logic [6:0] opAddr_ff;
    logic [7:0] acc_ff;
    logic [7:0] file_ff;
    logic carry_ff;
    logic digitCarry_ff;
    logic zero_ff;
    logic timeout_flag_ff;
    logic power_down_flag_ff;
    logic [7:0] watchdog_counter_ff;
    logic [PW-1:0] prescale_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [6:0] fileAddr_ff;
    logic [7:0] fileWrData_ff;
    logic fileWrEn_ff;
    logic sleeping_ff;

    logic apbSetup;
    logic apbWrite;
    logic idleWrite;
    logic addrHit;
    logic goReq;
    logic execNow;
    logic isSleep;
    logic prescaleTick;
    logic [31:0] nxt_prdata;
    alu_req_t req;
    alu_res_t res;

    // Setup phase is seen one cycle before the access phase completes
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite & pready_ff;
    assign idleWrite = apbWrite & (state_ff == ST_IDLE);
    assign goReq = apbWrite & (paddr == OFS_CTRL) & pwdata[CTRL_GO_BIT];
    assign execNow = (state_ff == ST_EXEC);
    assign isSleep = execNow & (op_code_t'(opSel_ff) == OP_SLEEP);

    // Address decode; misaligned or high offsets answer with an error
    always_comb begin
        addrHit = 1'b0;
        case (paddr)
            OFS_CTRL, OFS_OPER, OFS_ACC, OFS_FILE, OFS_STAT, OFS_WDOG:
                addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    end

    // Request to the datapath built from latched operands
    always_comb begin
        req.op = op_code_t'(opSel_ff);
        req.destFile = destFile_ff;
        req.fileVal = file_ff;
        req.accVal = acc_ff;
        req.literal = literal_ff;
        req.carryIn = carry_ff;
    end

    alu_ops_core u_core (
        .req(req),
        .res(res)
    );

    // APB answers in the cycle after setup: one wait-free access phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= apbSetup;
        end
    end

    // Error answer for holes in the map; such writes change nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= apbSetup & ~addrHit;
        end
    end

    // Read mux, registered so prdata comes from a flip-flop
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: begin
                nxt_prdata[CTRL_OP_LSB +: 4] = opSel_ff;
                nxt_prdata[CTRL_DEST_BIT] = destFile_ff;
                nxt_prdata[CTRL_GO_BIT] = (state_ff != ST_IDLE);
            end
            OFS_OPER: begin
                nxt_prdata[7:0] = literal_ff;
                nxt_prdata[OPER_ADDR_LSB +: 7] = opAddr_ff;
            end
            OFS_ACC: nxt_prdata[7:0] = acc_ff;
            OFS_FILE: nxt_prdata[7:0] = file_ff;
            OFS_STAT: begin
                nxt_prdata[STAT_C_BIT] = carry_ff;
                nxt_prdata[STAT_DC_BIT] = digitCarry_ff;
                nxt_prdata[STAT_Z_BIT] = zero_ff;
                nxt_prdata[STAT_PD_BIT] = power_down_flag_ff;
                nxt_prdata[STAT_TO_BIT] = timeout_flag_ff;
            end
            OFS_WDOG: nxt_prdata[7:0] = watchdog_counter_ff;
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // Read data captured at setup so it stands in the access cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (apbSetup && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Control register; ignored while an operation runs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            opSel_ff <= 4'h0;
            destFile_ff <= 1'b1;
        end else if (idleWrite && paddr == OFS_CTRL) begin
            opSel_ff <= pwdata[CTRL_OP_LSB +: 4];
            destFile_ff <= pwdata[CTRL_DEST_BIT];
        end
    end

    // Operand register: literal and file address; ignored while busy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            literal_ff <= 8'h00;
            opAddr_ff <= 7'h00;
        end else if (idleWrite && paddr == OFS_OPER) begin
            literal_ff <= pwdata[7:0];
            opAddr_ff <= pwdata[OPER_ADDR_LSB +: 7];
        end
    end

    // Sequencer: a start pulse runs one operation in one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: if (goReq) state_ff <= ST_EXEC;
                ST_EXEC: state_ff <= ST_DONE;
                ST_DONE: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Accumulator: software load, or datapath result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_ff <= ACC_RST;
        end else if (execNow && res.toAcc) begin
            acc_ff <= res.result;
        end else if (idleWrite && paddr == OFS_ACC) begin
            acc_ff <= pwdata[7:0];
        end
    end

    // File operand mirror, written back when destination is the file
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            file_ff <= 8'h00;
        end else if (execNow && res.toFile) begin
            file_ff <= res.result;
        end else if (idleWrite && paddr == OFS_FILE) begin
            file_ff <= pwdata[7:0];
        end
    end

    // Carry: rotates and subtracts update it, swap and sleep do not
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            carry_ff <= STAT_RST[STAT_C_BIT];
        end else if (execNow) begin
            if (res.updC) carry_ff <= res.carry;
        end else if (idleWrite && paddr == OFS_STAT) begin
            carry_ff <= pwdata[STAT_C_BIT];
        end
    end

    // Digit carry and zero move only with the subtract forms or a status register write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            digitCarry_ff <= STAT_RST[STAT_DC_BIT];
            zero_ff <= STAT_RST[STAT_Z_BIT];
        end else if (execNow) begin
            if (res.updDcZ) begin
                digitCarry_ff <= res.digitCarry;
                zero_ff <= res.zero;
            end
        end else if (idleWrite && paddr == OFS_STAT) begin
            digitCarry_ff <= pwdata[STAT_DC_BIT];
            zero_ff <= pwdata[STAT_Z_BIT];
        end
    end

    // Power status flags only change on sleep; software cannot write them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timeout_flag_ff <= STAT_RST[STAT_TO_BIT];
            power_down_flag_ff <= STAT_RST[STAT_PD_BIT];
        end else if (isSleep) begin
            timeout_flag_ff <= 1'b1;
            power_down_flag_ff <= 1'b0;
        end
    end

    // Watchdog prescaler and counter; sleep clears both together
    assign prescaleTick = (prescale_ff == PW'(PRESCALE - 1));

    always_ff @(posedge clk) begin
        if (!rst_n || isSleep) begin
            prescale_ff <= '0;
        end else if (prescaleTick) begin
            prescale_ff <= '0;
        end else begin
            prescale_ff <= prescale_ff + PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || isSleep) begin
            watchdog_counter_ff <= WDOG_CLEAR;
        end else if (prescaleTick) begin
            watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
        end
    end

    // File port address follows the operand register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fileAddr_ff <= 7'h00;
        end else begin
            fileAddr_ff <= opAddr_ff;
        end
    end

    // Write data tracks the datapath; only the strobe qualifies it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fileWrData_ff <= 8'h00;
        end else begin
            fileWrData_ff <= res.result;
        end
    end

    // One-cycle write strobe for results routed to the file
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fileWrEn_ff <= 1'b0;
        end else begin
            fileWrEn_ff <= execNow & res.toFile;
        end
    end

    // Sleep level holds until the next start request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleeping_ff <= 1'b0;
        end else if (isSleep) begin
            sleeping_ff <= 1'b1;
        end else if (goReq) begin
            sleeping_ff <= 1'b0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign fileAddr = fileAddr_ff;
    assign fileWrData = fileWrData_ff;
    assign fileWrEn = fileWrEn_ff;
    assign sleeping = sleeping_ff;

endmodule : rotate_subtract_swap_alu
`default_nettype wire

// File: alu_ops_pkg.sv
// Package for the rotate, subtract, swap and sleep execution block
package alu_ops_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OPER = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_FILE = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_WDOG = 8'h14;

    // CTRL and OPER field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_DEST_BIT = 4;
    localparam int CTRL_GO_BIT = 8;
    localparam int OPER_ADDR_LSB = 8;

    // STAT field positions
    localparam int STAT_C_BIT = 0;
    localparam int STAT_DC_BIT = 1;
    localparam int STAT_Z_BIT = 2;
    localparam int STAT_PD_BIT = 3;
    localparam int STAT_TO_BIT = 4;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [4:0] STAT_RST = 5'h18;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;

    // Watchdog prescaler ratio in clock cycles
    localparam int WDOG_PRESCALE = 16;

    // Operation codes
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ROT_RIGHT = 4'h1,
        OP_ROT_LEFT = 4'h2,
        OP_LIT_SUB = 4'h3,
        OP_FILE_SUB = 4'h4,
        OP_BORROW_SUB = 4'h5,
        OP_SWAP = 4'h6,
        OP_SLEEP = 4'h7
    } op_code_t;

    // Operation request into the datapath
    typedef struct packed {
        op_code_t op;
        logic destFile;
        logic [7:0] fileVal;
        logic [7:0] accVal;
        logic [7:0] literal;
        logic carryIn;
    } alu_req_t;

    // Datapath answer
    typedef struct packed {
        logic [7:0] result;
        logic carry;
        logic digitCarry;
        logic zero;
        logic updC;
        logic updDcZ;
        logic toAcc;
        logic toFile;
    } alu_res_t;

endpackage : alu_ops_pkg

// File: alu_ops_core.sv
// Combinational datapath for rotate, subtract and swap operations
`timescale 1ns/1ps
`default_nettype none
module alu_ops_core
    import alu_ops_pkg::*;
(
    input wire alu_req_t req,
    output var alu_res_t res
);

    // Differences as a + ~b + cIn; a carry-in of one means no borrow,
    // so the top bit comes out as the carry flag directly
    function automatic logic [8:0] sub9(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic cIn);
        sub9 = {1'b0, a} + {1'b0, ~b} + {8'h00, cIn};
    endfunction : sub9

    function automatic logic [4:0] sub5(input logic [3:0] a,
                                        input logic [3:0] b,
                                        input logic cIn);
        sub5 = {1'b0, a} + {1'b0, ~b} + {4'h0, cIn};
    endfunction : sub5

    logic [8:0] diff;
    logic [4:0] diffLo;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic borrowIn;

    // Operand choice for the three subtract forms
    always_comb begin
        minuend = req.fileVal;
        subtrahend = req.accVal;
        borrowIn = 1'b1;
        case (req.op)
            OP_LIT_SUB: begin
                minuend = req.literal;
                subtrahend = req.accVal;
            end
            OP_BORROW_SUB: begin
                // Accumulator is the minuend; a clear carry is a borrow
                minuend = req.accVal;
                subtrahend = req.fileVal;
                borrowIn = req.carryIn;
            end
            default: begin
                minuend = req.fileVal;
                subtrahend = req.accVal;
            end
        endcase
    end

    assign diff = sub9(minuend, subtrahend, borrowIn);
    assign diffLo = sub5(minuend[3:0], subtrahend[3:0], borrowIn);

    // Result, flags and destination per operation
    always_comb begin
        res = '0;
        res.toAcc = ~req.destFile;
        res.toFile = req.destFile;
        case (req.op)
            OP_ROT_RIGHT: begin
                res.result = {req.carryIn, req.fileVal[7:1]};
                res.carry = req.fileVal[0];
                res.updC = 1'b1;
            end
            OP_ROT_LEFT: begin
                res.result = {req.fileVal[6:0], req.carryIn};
                res.carry = req.fileVal[7];
                res.updC = 1'b1;
            end
            OP_LIT_SUB, OP_FILE_SUB, OP_BORROW_SUB: begin
                res.result = diff[7:0];
                res.carry = diff[8];
                res.digitCarry = diffLo[4];
                res.zero = (diff[7:0] == 8'h00);
                res.updC = 1'b1;
                res.updDcZ = 1'b1;
                if (req.op == OP_LIT_SUB) begin
                    res.toAcc = 1'b1;
                    res.toFile = 1'b0;
                end
            end
            OP_SWAP: begin
                res.result = {req.fileVal[3:0], req.fileVal[7:4]};
            end
            default: begin
                res.toAcc = 1'b0;
                res.toFile = 1'b0;
            end
        endcase
    end

endmodule : alu_ops_core
`default_nettype wire

// File: rotate_subtract_swap_alu_sva.sv
// Checker for the rotate, subtract, swap and sleep block
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_swap_alu_sva
    import alu_ops_pkg::*;
#(
    parameter int PRESCALE = WDOG_PRESCALE
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [6:0] fileAddr,
    input wire logic [7:0] fileWrData,
    input wire logic fileWrEn,
    input wire logic sleeping
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] fileSh_ff;
    logic [7:0] accSh_ff;
    logic wr;
    logic go;
    logic goF;
    logic [3:0] op;
    // Decode completed writes; GO with destination in file
    assign wr = psel && penable && pready && pwrite;
    assign go = wr && paddr == OFS_CTRL && pwdata[CTRL_GO_BIT];
    assign goF = go && pwdata[CTRL_DEST_BIT];
    assign op = pwdata[3:0];
    // Operand shadows; valid only while nobody writes during a busy op
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fileSh_ff <= 8'h00;
            accSh_ff <= 8'h00;
        end else begin
            if (wr && paddr == OFS_FILE) fileSh_ff <= pwdata[7:0];
            if (wr && paddr == OFS_ACC) accSh_ff <= pwdata[7:0];
        end
    end
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property
        (psel && !penable && paddr > OFS_WDOG |=> pslverr)
        else $error("no error on unmapped address");
    a_file_route: assert property (goF && op inside {1, 2, 4, 5, 6}
        |-> ##2 fileWrEn) else $error("file write missing");
    a_acc_route: assert property (go && !pwdata[CTRL_DEST_BIT]
        |-> ##1 !fileWrEn [*2]) else $error("file written for dest 0");
    a_lit_to_acc: assert property (go && op == OP_LIT_SUB
        |-> ##2 !fileWrEn) else $error("literal result left acc");
    a_sleep_flag: assert property (go && op == OP_SLEEP
        |-> ##[1:3] sleeping) else $error("sleep level missing");
    a_swap_data: assert property (goF && op == OP_SWAP |-> ##2
        fileWrData == {fileSh_ff[3:0], fileSh_ff[7:4]})
        else $error("swap result wrong");
    a_sub_data: assert property (goF && op == OP_FILE_SUB |-> ##2
        fileWrData == 8'(fileSh_ff - accSh_ff))
        else $error("file subtract result wrong");
    a_right_data: assert property (goF && op == OP_ROT_RIGHT |-> ##2
        fileWrData[6:0] == fileSh_ff[7:1])
        else $error("rotate right result wrong");
    a_left_data: assert property (goF && op == OP_ROT_LEFT |-> ##2
        fileWrData[7:1] == fileSh_ff[6:0])
        else $error("rotate left result wrong");
    c_sleep: cover property (go && op == OP_SLEEP);
    c_file_write: cover property (fileWrEn);
    c_bus_error: cover property (pslverr);
endmodule : rotate_subtract_swap_alu_sva

bind rotate_subtract_swap_alu rotate_subtract_swap_alu_sva #(
    .PRESCALE(PRESCALE)
) i_sva (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fileAddr(fileAddr),
    .fileWrData(fileWrData), .fileWrEn(fileWrEn), .sleeping(sleeping));
`default_nettype wire

// File: rotate_subtract_swap_alu_tb_top.sv
// Self-checking testbench for the rotate, subtract, swap and sleep block
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_swap_alu_tb_top
    import alu_ops_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] fileAddr;
    logic [7:0] fileWrData;
    logic fileWrEn;
    logic sleeping;
    logic [31:0] rd;
    logic err;
    logic pdExp = 1'b1;
    int n_fail = 0;
    int check_count = 0;
    // Op vectors: {op, dest, flags zdc c, literal, acc, file}
    logic [31:0] vec [15] = '{32'h1F00_00E6, 32'h1600_0001, 32'h7D00_0000,
        32'h2000_00E6, 32'h2900_0081, 32'h3802_0200, 32'h3401_0200,
        32'h4800_0110, 32'h4300_0303, 32'h5800_0503, 32'h5400_0000,
        32'h5900_1303, 32'h6D00_00A5, 32'h6200_003C, 32'h1F00_0055};

    // Clock at 50 MHz
    always #10 clk = ~clk;

    // Short prescaler keeps the watchdog readable within a few ops
    rotate_subtract_swap_alu #(.PRESCALE(2)) i_dut (.clk(clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fileAddr(fileAddr), .fileWrData(fileWrData),
        .fileWrEn(fileWrEn), .sleeping(sleeping));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    // One APB transfer; an idle edge follows so drives never collide
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the hang guard ends a wait for the slave
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Expected {zero, digit carry, carry, result}
    function automatic logic [10:0] model(input logic [3:0] op,
            input logic [7:0] l, a, f, input logic [2:0] fl);
        logic [8:0] d;
        logic [4:0] n;
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] r;
        logic b;
        logic [2:0] o;
        o = fl;
        r = 8'h00;
        x = f;
        y = a;
        b = 1'b0;
        case (op)
            4'h1: begin
                r = {fl[0], f[7:1]};
                o[0] = f[0];
            end
            4'h2: begin
                r = {f[6:0], fl[0]};
                o[0] = f[7];
            end
            4'h6: r = {f[3:0], f[7:4]};
            4'h3: x = l;
            4'h5: begin
                x = a;
                y = f;
                b = ~fl[0];
            end
            default: ;
        endcase
        // Borrow out of the top bit or the low nibble clears the flag
        if (op inside {4'h3, 4'h4, 4'h5}) begin
            d = {1'b0, x} - {1'b0, y} - b;
            n = {1'b0, x[3:0]} - {1'b0, y[3:0]} - b;
            r = d[7:0];
            o = {d[7:0] == 8'h00, ~n[4], ~d[8]};
        end
        return {o, r};
    endfunction : model

    // Load operands, execute, then read back every affected register
    task automatic run(input logic [31:0] v);
        logic [10:0] m;
        logic toF;
        logic toA;
        int i;
        m = model(v[31:28], v[23:16], v[15:8], v[7:0], v[26:24]);
        toF = v[27] && v[31:28] inside {1, 2, 4, 5, 6};
        toA = v[31:28] == 4'h3 || (!v[27] && v[31:28] != 4'h7);
        if (v[31:28] == 4'h7) begin
            apb(1'b0, OFS_WDOG, 32'h0);
            check(rd[7:0] >= 8'h08, 1'b1);
        end
        apb(1'b1, OFS_OPER, {17'h0_0000, v[6:0], v[23:16]});
        apb(1'b1, OFS_ACC, {24'h00_0000, v[15:8]});
        apb(1'b1, OFS_FILE, {24'h00_0000, v[7:0]});
        apb(1'b1, OFS_STAT, {29'h0000_0000, v[26:24]});
        apb(1'b1, OFS_CTRL, {24'h00_0001, 3'h0, v[27], v[31:28]});
        rd = 32'h0000_0100;
        for (i = 0; i < 10 && rd[8] !== 1'b0; i++) begin
            apb(1'b0, OFS_CTRL, 32'h0000_0000);
        end
        check(rd[8], 1'b0);
        if (v[31:28] == 4'h7) begin
            pdExp = 1'b0;
            apb(1'b0, OFS_WDOG, 32'h0);
            check(rd[7:0] < 8'h04, 1'b1);
        end
        apb(1'b0, OFS_ACC, 32'h0);
        check(rd, {24'h00_0000, toA ? m[7:0] : v[15:8]});
        apb(1'b0, OFS_FILE, 32'h0);
        check(rd, {24'h00_0000, toF ? m[7:0] : v[7:0]});
        apb(1'b0, OFS_STAT, 32'h0);
        check(rd, {27'h000_0000, 1'b1, pdExp, m[10:8]});
        check(fileAddr, v[6:0]);
        check(sleeping, v[31:28] == 4'h7);
    endtask : run

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (vec[k]) run(vec[k]);
        apb(1'b0, 8'h18, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_STAT, 32'h0);
        check(rd, 32'h0000_0018);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0000_0010);
        apb(1'b0, OFS_ACC, 32'h0);
        check(rd, 32'h0000_0000);
        results();
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_fail++;
        results();
    end
endmodule : rotate_subtract_swap_alu_tb_top
`default_nettype wire
